// >>> design/radio_test_pkg.sv
package radio_test_pkg;

	// register port geometry
	localparam int ADDR_W = 7;
	localparam int DATA_W = 8;
	localparam logic [2:0] BIT_LAST = 3'h7;

	// register offsets on the serial port
	localparam logic [6:0] OFS_DEMOD_TEST = 7'h56;
	localparam logic [6:0] OFS_PUMP_FORCE = 7'h57;
	localparam logic [6:0] OFS_PUMP_GAIN = 7'h58;
	localparam logic [6:0] OFS_DIV_TRIM = 7'h59;
	localparam logic [6:0] OFS_VCO_TRIM = 7'h5A;
	localparam logic [6:0] OFS_VCO_CAL = 7'h5B;

	// reset values, and the value read at unmapped offsets
	localparam logic [7:0] RST_DEMOD_TEST = 8'h00;
	localparam logic [7:0] RST_PUMP_FORCE = 8'h00;
	localparam logic [1:0] RST_PUMP_GAIN = 2'h2;
	localparam logic RST_PUMP_OV = 1'b0;
	localparam logic [4:0] RST_PUMP_CORR = 5'h00;
	localparam logic [7:0] RST_DIV_TRIM = 8'h00;
	localparam logic [7:0] RST_VCO_TRIM = 8'h03;
	localparam logic [6:0] RST_VCO_CAL = 7'h00;
	localparam logic [7:0] RD_UNMAPPED = 8'h00;

	// slicer threshold lengths in preamble bits
	localparam logic [3:0] OOK_LEN_LONG = 4'h8;
	localparam logic [3:0] OOK_LEN_SHORT = 4'h4;

	// forced oscillator values while transmitting
	localparam logic [3:0] VCO_CORR_BOOST = 4'hF;
	localparam logic [1:0] VCO_CUR_BOOST = 2'h3;

	typedef struct packed {
		logic bcr_comp_bypass;
		logic slicer_comp_bypass;
		logic dither_pm1_only;
		logic osc_detect_off;
		logic ook_th_long;
		logic dsm_ref_10mhz;
		logic dsm_ref_invert;
		logic disc_toggle_en;
	} demod_test_t;

	typedef struct packed {
		logic pfd_reset;
		logic fbdiv_reset;
		logic force_up;
		logic force_down;
		logic dc_offset_only;
		logic [2:0] dc_current;
	} pump_force_t;

	typedef struct packed {
		logic [1:0] gain;
		logic corr_ov;
		logic [4:0] corr;
	} pump_gain_t;

	typedef struct packed {
		logic corr_boost;
		logic fbdiv_high_cur;
		logic [1:0] div3_trim;
		logic [1:0] div2_trim;
		logic [1:0] div1p5_trim;
	} div_trim_t;

	typedef struct packed {
		logic cur_boost;
		logic corr_ov;
		logic [3:0] corr;
		logic [1:0] cur;
	} vco_trim_t;

endpackage : radio_test_pkg

// >>> design/spi_reg_port.sv
module spi_reg_port import radio_test_pkg::*; (
	input wire logic clk, // system clock
	input wire logic rstn, // synchronous reset, active low
	input wire logic ce, // clock enable
	input wire logic sel_n, // serial select pin, active low
	input wire logic sck, // serial clock pin
	input wire logic sdi, // serial data pin from host
	output logic sdo, // serial data toward host
	output logic sdo_oe, // sdo driven while selected
	output logic [ADDR_W-1:0] rd_addr, // address being read
	input wire logic [DATA_W-1:0] rd_data, // read data for rd_addr
	output logic wr_en, // one-cycle write strobe
	output logic [ADDR_W-1:0] wr_addr, // write address
	output logic [DATA_W-1:0] wr_data // write data
);
	logic [2:0] sck_sync_ff;
	logic [1:0] sel_sync_ff;
	logic [1:0] sdi_sync_ff;
	logic [2:0] bit_cnt_ff;
	logic [7:0] in_sh_ff;
	logic [7:0] out_sh_ff;
	logic hdr_done_ff;
	logic is_wr_ff;
	logic load_ff;
	logic [ADDR_W-1:0] addr_ff;
	logic sdo_ff;
	logic oe_ff;
	logic wr_en_ff;
	logic [ADDR_W-1:0] wr_addr_ff;
	logic [DATA_W-1:0] wr_data_ff;
	logic sck_rise;
	logic sck_fall;
	logic active;
	logic [7:0] nxt_byte;

	// pins are asynchronous; the host must keep sck well below clk/8
	always_ff @(posedge clk) begin
		if (!rstn) begin
			sck_sync_ff <= 3'h0;
			sel_sync_ff <= 2'h3;
			sdi_sync_ff <= 2'h0;
		end else if (ce) begin
			sck_sync_ff <= {sck_sync_ff[1:0], sck};
			sel_sync_ff <= {sel_sync_ff[0], sel_n};
			sdi_sync_ff <= {sdi_sync_ff[0], sdi};
		end
	end

	assign sck_rise = sck_sync_ff[1] & ~sck_sync_ff[2];
	assign sck_fall = ~sck_sync_ff[1] & sck_sync_ff[2];
	assign active = ~sel_sync_ff[1];
	assign nxt_byte = {in_sh_ff[6:0], sdi_sync_ff[1]};

	// first byte is write flag and address, then data bytes with auto-increment
	always_ff @(posedge clk) begin
		if (!rstn) begin
			bit_cnt_ff <= 3'h0;
			in_sh_ff <= 8'h00;
			out_sh_ff <= 8'h00;
			hdr_done_ff <= 1'b0;
			is_wr_ff <= 1'b0;
			load_ff <= 1'b0;
			addr_ff <= 7'h00;
			sdo_ff <= 1'b0;
			oe_ff <= 1'b0;
			wr_en_ff <= 1'b0;
			wr_addr_ff <= 7'h00;
			wr_data_ff <= 8'h00;
		end else if (ce) begin
			wr_en_ff <= 1'b0;
			load_ff <= 1'b0;
			oe_ff <= active;
			if (!active) begin
				bit_cnt_ff <= 3'h0;
				hdr_done_ff <= 1'b0;
				sdo_ff <= 1'b0;
			end else begin
				if (sck_rise) begin
					in_sh_ff <= nxt_byte;
					bit_cnt_ff <= bit_cnt_ff + 3'h1;
					if (bit_cnt_ff == BIT_LAST) begin
						load_ff <= 1'b1;
						if (!hdr_done_ff) begin
							hdr_done_ff <= 1'b1;
							is_wr_ff <= nxt_byte[7];
							addr_ff <= nxt_byte[6:0];
						end else begin
							addr_ff <= addr_ff + 7'h01;
							wr_en_ff <= is_wr_ff;
							wr_addr_ff <= addr_ff;
							wr_data_ff <= nxt_byte;
						end
					end
				end
				if (sck_fall) begin
					sdo_ff <= out_sh_ff[7];
					out_sh_ff <= {out_sh_ff[6:0], 1'b0};
				end
				// reload lands one cycle after the byte edge, long before the next fall
				if (load_ff) begin
					out_sh_ff <= rd_data;
				end
			end
		end
	end

	assign sdo = sdo_ff;
	assign sdo_oe = oe_ff;
	assign rd_addr = addr_ff;
	assign wr_en = wr_en_ff;
	assign wr_addr = wr_addr_ff;
	assign wr_data = wr_data_ff;

endmodule : spi_reg_port

// >>> design/radio_modem_synth_test_regs.sv
// How it works
// RQ1: bit 7 bypasses clock-recovery phase compensation
// RQ2: bit 6 bypasses slicer phase compensation
// RQ3: dither type picks plus-minus-one-or-zero versus plus-minus-one
// RQ4: oscillation detection runs unless disable bit set
// RQ5: slicer threshold over eight or four bits
// RQ6: reference source ten megahertz or synthesizer
// RQ7: reference inversion bit inverts modulator reference
// RQ8: cleared toggle bit disables discriminator toggling
// RQ9: modem test resets zero, fully read-write
// RQ10: pump force up and down bits
// RQ11: detector and divider resets pass straight through
// RQ12: correction reads applied value without override
// RQ13: override drives and reads written correction
// RQ14: gain resets 10, override 0, correction zero
// RQ15: divider boost forces correction all ones transmitting
// RQ16: oscillator boost forces current trim 11 transmitting
// RQ17: oscillator trim resets 03 with fixed layout
// RQ18: without override, calibration reads internal result
// RQ19: override applies host-written calibration value
// RQ20: calibration bit 7 reads done status
// RQ21: other trim fields stored and driven out
module radio_modem_synth_test_regs import radio_test_pkg::*; (
	input wire logic clk, // system clock
	input wire logic rstn, // synchronous reset, active low
	input wire logic ce, // clock enable, freezes all state when low
	input wire logic spi_sel_n, // serial select pin, active low
	input wire logic spi_sck, // serial clock pin
	input wire logic spi_sdi, // serial data in pin
	output logic spi_sdo, // serial data out pin
	output logic spi_sdo_oe, // high while sdo is driven
	input wire logic tx_active, // transmit or calibration ahead of transmit
	input wire logic [4:0] pump_corr_auto, // correction from pump loop
	input wire logic [6:0] vco_cal_code, // internal calibration result
	input wire logic vco_cal_done, // calibration finished
	output demod_test_t demod_ctrl, // demodulator test controls
	output logic [3:0] ook_th_len, // slicer threshold length in bits
	output pump_force_t pump_force, // pump force and direct controls
	output logic [1:0] pump_gain, // pump current gain
	output logic [4:0] pump_corr_out, // correction applied to pump
	output div_trim_t div_trim, // divider current trims
	output logic [3:0] vco_corr_out, // oscillator current correction
	output logic [1:0] vco_cur_out, // oscillator current trim
	output logic vco_corr_ov, // oscillator correction override
	output logic [6:0] vco_cal_out // calibration value applied
);

	function automatic logic [3:0] boost_nib(input logic en, input logic [3:0] forced, input logic [3:0] plain);
		boost_nib = en ? forced : plain;
	endfunction : boost_nib

	logic [ADDR_W-1:0] rd_addr;
	logic [DATA_W-1:0] rd_data;
	logic wr_en;
	logic [ADDR_W-1:0] wr_addr;
	logic [DATA_W-1:0] wr_data;

	demod_test_t demod_ff;
	pump_force_t pump_force_ff;
	pump_gain_t gain_ff;
	div_trim_t div_ff;
	vco_trim_t vco_ff;
	logic cal_ov_ff;
	logic [6:0] cal_wr_ff;

	logic [3:0] ook_len_ff;
	logic [4:0] pump_corr_ff;
	logic [3:0] vco_corr_ff;
	logic [1:0] vco_cur_ff;
	logic [6:0] vco_cal_ff;

	logic [3:0] nxt_vco_corr;
	logic [3:0] nxt_vco_cur;

	spi_reg_port u_port (
		.clk(clk),
		.rstn(rstn),
		.ce(ce),
		.sel_n(spi_sel_n),
		.sck(spi_sck),
		.sdi(spi_sdi),
		.sdo(spi_sdo),
		.sdo_oe(spi_sdo_oe),
		.rd_addr(rd_addr),
		.rd_data(rd_data),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data)
	);

	// modem test: every bit is a plain control toward the demodulator
	always_ff @(posedge clk) begin
		if (!rstn) begin
			demod_ff <= RST_DEMOD_TEST; // RQ9
		end else if (ce && wr_en && wr_addr == OFS_DEMOD_TEST) begin
			demod_ff <= wr_data; // RQ1 RQ2 RQ3 RQ4 RQ6 RQ7 RQ8 RQ9
		end
	end

	// slicer threshold length follows the length bit
	always_ff @(posedge clk) begin
		if (!rstn) begin
			ook_len_ff <= OOK_LEN_SHORT;
		end else if (ce) begin
			ook_len_ff <= demod_ff.ook_th_long ? OOK_LEN_LONG : OOK_LEN_SHORT; // RQ5
		end
	end

	// pump force and direct analog controls
	always_ff @(posedge clk) begin
		if (!rstn) begin
			pump_force_ff <= RST_PUMP_FORCE;
		end else if (ce && wr_en && wr_addr == OFS_PUMP_FORCE) begin
			pump_force_ff <= wr_data; // RQ10 RQ11
		end
	end

	// pump gain, override and host correction value
	always_ff @(posedge clk) begin
		if (!rstn) begin
			gain_ff <= {RST_PUMP_GAIN, RST_PUMP_OV, RST_PUMP_CORR}; // RQ14
		end else if (ce && wr_en && wr_addr == OFS_PUMP_GAIN) begin
			gain_ff <= wr_data;
		end
	end

	// applied pump correction: one register shared by the pump and readback
	always_ff @(posedge clk) begin
		if (!rstn) begin
			pump_corr_ff <= RST_PUMP_CORR; // RQ14
		end else if (ce) begin
			pump_corr_ff <= gain_ff.corr_ov ? gain_ff.corr : pump_corr_auto; // RQ12 RQ13
		end
	end

	// divider trims
	always_ff @(posedge clk) begin
		if (!rstn) begin
			div_ff <= RST_DIV_TRIM;
		end else if (ce && wr_en && wr_addr == OFS_DIV_TRIM) begin
			div_ff <= wr_data; // RQ21
		end
	end

	// oscillator current trim
	always_ff @(posedge clk) begin
		if (!rstn) begin
			vco_ff <= RST_VCO_TRIM; // RQ17
		end else if (ce && wr_en && wr_addr == OFS_VCO_TRIM) begin
			vco_ff <= wr_data; // RQ17
		end
	end

	// boosts only bite while transmitting; stored fields stay as written
	assign nxt_vco_corr = boost_nib(div_ff.corr_boost && tx_active, VCO_CORR_BOOST, vco_ff.corr);
	assign nxt_vco_cur = boost_nib(vco_ff.cur_boost && tx_active, {2'h0, VCO_CUR_BOOST}, {2'h0, vco_ff.cur});

	always_ff @(posedge clk) begin
		if (!rstn) begin
			vco_corr_ff <= RST_VCO_TRIM[5:2];
			vco_cur_ff <= RST_VCO_TRIM[1:0];
		end else if (ce) begin
			vco_corr_ff <= nxt_vco_corr; // RQ15
			vco_cur_ff <= nxt_vco_cur[1:0]; // RQ16
		end
	end

	// calibration override and host value
	always_ff @(posedge clk) begin
		if (!rstn) begin
			cal_ov_ff <= 1'b0;
			cal_wr_ff <= RST_VCO_CAL;
		end else if (ce && wr_en && wr_addr == OFS_VCO_CAL) begin
			cal_ov_ff <= wr_data[7];
			cal_wr_ff <= wr_data[6:0]; // RQ19
		end
	end

	// applied calibration value, also what software reads back
	always_ff @(posedge clk) begin
		if (!rstn) begin
			vco_cal_ff <= RST_VCO_CAL;
		end else if (ce) begin
			vco_cal_ff <= cal_ov_ff ? cal_wr_ff : vco_cal_code; // RQ18 RQ19
		end
	end

	// read side; the override bit is write-only, its read position carries done
	always_comb begin
		case (rd_addr)
			OFS_DEMOD_TEST: rd_data = demod_ff; // RQ9
			OFS_PUMP_FORCE: rd_data = pump_force_ff;
			OFS_PUMP_GAIN: rd_data = {gain_ff.gain, gain_ff.corr_ov, pump_corr_ff}; // RQ12 RQ13
			OFS_DIV_TRIM: rd_data = div_ff;
			OFS_VCO_TRIM: rd_data = vco_ff;
			OFS_VCO_CAL: rd_data = {vco_cal_done, vco_cal_ff}; // RQ18 RQ20
			default: rd_data = RD_UNMAPPED;
		endcase
	end

	assign demod_ctrl = demod_ff;
	assign ook_th_len = ook_len_ff;
	assign pump_force = pump_force_ff; // RQ11
	assign pump_gain = gain_ff.gain;
	assign pump_corr_out = pump_corr_ff;
	assign div_trim = div_ff;
	assign vco_corr_out = vco_corr_ff;
	assign vco_cur_out = vco_cur_ff;
	assign vco_corr_ov = vco_ff.corr_ov;
	assign vco_cal_out = vco_cal_ff;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	property p_demod_reset;
		$rose(rstn) |-> demod_ff == RST_DEMOD_TEST && vco_ff == RST_VCO_TRIM;
	endproperty
	a_demod_reset: assert property (p_demod_reset) else $error("trim reset values wrong"); // RQ9

	property p_demod_write;
		ce && wr_en && wr_addr == OFS_DEMOD_TEST |=> demod_ctrl == $past(wr_data);
	endproperty
	a_demod_write: assert property (p_demod_write) else $error("modem test write lost"); // RQ1

	property p_ook_len;
		ce |=> ook_th_len == ($past(demod_ff.ook_th_long) ? OOK_LEN_LONG : OOK_LEN_SHORT);
	endproperty
	a_ook_len: assert property (p_ook_len) else $error("threshold length wrong"); // RQ5

	property p_force_write;
		ce && wr_en && wr_addr == OFS_PUMP_FORCE |=> pump_force == $past(wr_data);
	endproperty
	a_force_write: assert property (p_force_write) else $error("pump force not passed"); // RQ10

	property p_pump_auto;
		ce && !gain_ff.corr_ov |=> pump_corr_out == $past(pump_corr_auto);
	endproperty
	a_pump_auto: assert property (p_pump_auto) else $error("pump correction not tracking loop"); // RQ12

	property p_pump_ov;
		ce && gain_ff.corr_ov |=> pump_corr_out == $past(gain_ff.corr);
	endproperty
	a_pump_ov: assert property (p_pump_ov) else $error("pump override not applied"); // RQ13

	property p_corr_boost;
		ce && div_ff.corr_boost && tx_active |=> vco_corr_out == VCO_CORR_BOOST;
	endproperty
	a_corr_boost: assert property (p_corr_boost) else $error("correction boost missing"); // RQ15

	property p_cur_boost;
		ce && vco_ff.cur_boost && tx_active |=> vco_cur_out == VCO_CUR_BOOST;
	endproperty
	a_cur_boost: assert property (p_cur_boost) else $error("current boost missing"); // RQ16

	property p_cur_plain;
		ce && !(vco_ff.cur_boost && tx_active) |=> vco_cur_out == $past(vco_ff.cur);
	endproperty
	a_cur_plain: assert property (p_cur_plain) else $error("current trim not as written"); // RQ16

	property p_cal_internal;
		ce && !cal_ov_ff |=> vco_cal_out == $past(vco_cal_code);
	endproperty
	a_cal_internal: assert property (p_cal_internal) else $error("calibration result not shown"); // RQ18

	property p_cal_override;
		ce && wr_en && wr_addr == OFS_VCO_CAL && wr_data[7] ##1 ce |=> vco_cal_out == $past(wr_data[6:0], 2);
	endproperty
	a_cal_override: assert property (p_cal_override) else $error("calibration override ignored"); // RQ19

	property p_cal_done_read;
		rd_addr == OFS_VCO_CAL |-> rd_data[7] == vco_cal_done && rd_data[6:0] == vco_cal_out;
	endproperty
	a_cal_done_read: assert property (p_cal_done_read) else $error("calibration readback wrong"); // RQ20

	property p_freeze;
		!ce |=> $stable(pump_corr_out) && $stable(vco_cal_out) && $stable(demod_ctrl);
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved with enable low");

	// the pump trim fields and the outputs that are derived rather than stored must also start from their reset values
	property p_reset_pump;
		$rose(rstn) |-> pump_gain == RST_PUMP_GAIN && gain_ff.corr_ov == RST_PUMP_OV
			&& pump_corr_out == RST_PUMP_CORR;
	endproperty
	a_reset_pump: assert property (p_reset_pump) else $error("pump trim reset values wrong"); // RQ14

	property p_reset_osc;
		$rose(rstn) |-> vco_corr_out == RST_VCO_TRIM[5:2] && vco_cur_out == RST_VCO_TRIM[1:0]
			&& vco_cal_out == RST_VCO_CAL;
	endproperty
	a_reset_osc: assert property (p_reset_osc) else $error("oscillator outputs reset wrong"); // RQ17

	property p_reset_ook;
		$rose(rstn) |-> ook_th_len == OOK_LEN_SHORT;
	endproperty
	a_reset_ook: assert property (p_reset_ook) else $error("threshold length reset wrong"); // RQ5

	property p_gain_write;
		ce && wr_en && wr_addr == OFS_PUMP_GAIN
			|=> {pump_gain, gain_ff.corr_ov, gain_ff.corr} == $past(wr_data);
	endproperty
	a_gain_write: assert property (p_gain_write) else $error("pump trim write lost"); // RQ13

	property p_div_write;
		ce && wr_en && wr_addr == OFS_DIV_TRIM |=> div_trim == $past(wr_data);
	endproperty
	a_div_write: assert property (p_div_write) else $error("divider trim write lost"); // RQ21

	property p_vco_write;
		ce && wr_en && wr_addr == OFS_VCO_TRIM
			|=> {vco_ff.cur_boost, vco_corr_ov, vco_ff.corr, vco_ff.cur} == $past(wr_data);
	endproperty
	a_vco_write: assert property (p_vco_write) else $error("oscillator trim write lost"); // RQ17

	property p_corr_plain;
		ce && !(div_ff.corr_boost && tx_active) |=> vco_corr_out == $past(vco_ff.corr);
	endproperty
	a_corr_plain: assert property (p_corr_plain) else $error("correction not as written"); // RQ15

	property p_cal_hold;
		ce && cal_ov_ff |=> vco_cal_out == $past(cal_wr_ff);
	endproperty
	a_cal_hold: assert property (p_cal_hold) else $error("calibration override not held"); // RQ19

	// a strobe that outlived its enabled cycle would store the same byte twice
	property p_wr_strobe;
		ce && wr_en |=> !wr_en;
	endproperty
	a_wr_strobe: assert property (p_wr_strobe) else $error("write strobe longer than one cycle");

	property p_demod_hold;
		ce && !(wr_en && wr_addr == OFS_DEMOD_TEST) |=> $stable(demod_ctrl);
	endproperty
	a_demod_hold: assert property (p_demod_hold) else $error("modem test changed without write"); // RQ9

	property p_force_hold;
		ce && !(wr_en && wr_addr == OFS_PUMP_FORCE) |=> $stable(pump_force);
	endproperty
	a_force_hold: assert property (p_force_hold) else $error("pump force changed without write"); // RQ11

	property p_gain_hold;
		ce && !(wr_en && wr_addr == OFS_PUMP_GAIN) |=> $stable(pump_gain) && $stable(gain_ff.corr_ov);
	endproperty
	a_gain_hold: assert property (p_gain_hold) else $error("pump gain changed without write"); // RQ21

	c_boost_tx: cover property (ce && vco_ff.cur_boost && div_ff.corr_boost && tx_active);
	c_pump_ov: cover property (ce && gain_ff.corr_ov && gain_ff.corr != pump_corr_auto);
	c_cal_ov: cover property (ce && wr_en && wr_addr == OFS_VCO_CAL && wr_data[7]);
	c_cal_read: cover property (rd_addr == OFS_VCO_CAL && vco_cal_done);
	c_ook_long: cover property (ce && demod_ff.ook_th_long);

endmodule : radio_modem_synth_test_regs

// >>> bench/spi_host_model.sv
module spi_host_model (
	input wire logic clk, // system clock, pacing only
	output logic sel_n, // select pin, active low
	output logic sck, // serial clock, low outside frames
	output logic sdi, // data toward the device
	input wire logic miso // resolved data line from the device
);
	timeunit 1ns;
	timeprecision 100ps;

	// six clocks per half period keeps sck above the four-cycle minimum with margin
	localparam int HALF = 6;

	initial begin
		sel_n = 1'b1;
		sck = 1'b0;
		sdi = 1'b1;
	end

	task automatic wait_clk(input int n);
		repeat (n) @(negedge clk);
	endtask : wait_clk

	task automatic open_frame();
		wait_clk(1);
		sel_n = 1'b0;
		wait_clk(HALF);
	endtask : open_frame

	// released data line shows the inverse of its last bit, so stale values never match by luck
	task automatic close_frame();
		wait_clk(HALF);
		sel_n = 1'b1;
		sdi = ~sdi;
		wait_clk(2 * HALF);
	endtask : close_frame

	// mode 0: data set while sck low, both sides sample at the rise
	task automatic xfer_byte(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			sdi = tx[i];
			wait_clk(HALF);
			sck = 1'b1;
			rx[i] = miso;
			wait_clk(HALF);
			sck = 1'b0;
		end
	endtask : xfer_byte
endmodule : spi_host_model

// >>> bench/tb_radio_modem_synth_test_regs.sv
module tb_radio_modem_synth_test_regs import radio_test_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;

	logic clk;
	logic rstn;
	logic ce;
	logic tx_active;
	logic [4:0] pump_corr_auto;
	logic [6:0] vco_cal_code;
	logic vco_cal_done;
	logic sel_n;
	logic sck;
	logic sdi;
	logic spi_sdo;
	logic spi_sdo_oe;
	logic miso;
	demod_test_t demod_ctrl;
	logic [3:0] ook_th_len;
	pump_force_t pump_force;
	logic [1:0] pump_gain;
	logic [4:0] pump_corr_out;
	div_trim_t div_trim;
	logic [3:0] vco_corr_out;
	logic [1:0] vco_cur_out;
	logic vco_corr_ov;
	logic [6:0] vco_cal_out;
	int n_mismatch = 0;
	int checks_done = 0;
	logic [7:0] rx;

	// pull-up assumed while the device leaves the line undriven
	assign miso = spi_sdo_oe ? spi_sdo : 1'b1;

	always #2.5 clk = ~clk;

	radio_modem_synth_test_regs i_dut (.clk(clk), .rstn(rstn), .ce(ce), .spi_sel_n(sel_n), .spi_sck(sck),
		.spi_sdi(sdi), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe), .tx_active(tx_active),
		.pump_corr_auto(pump_corr_auto), .vco_cal_code(vco_cal_code), .vco_cal_done(vco_cal_done),
		.demod_ctrl(demod_ctrl), .ook_th_len(ook_th_len), .pump_force(pump_force), .pump_gain(pump_gain),
		.pump_corr_out(pump_corr_out), .div_trim(div_trim), .vco_corr_out(vco_corr_out),
		.vco_cur_out(vco_cur_out), .vco_corr_ov(vco_corr_ov), .vco_cal_out(vco_cal_out));

	spi_host_model i_host (.clk(clk), .sel_n(sel_n), .sck(sck), .sdi(sdi), .miso(miso));

	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : conclude

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [7:0] r;
		i_host.open_frame();
		i_host.xfer_byte({1'b1, a}, r);
		i_host.xfer_byte(d, r);
		i_host.close_frame();
	endtask : wr

	task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
		logic [7:0] r;
		i_host.open_frame();
		i_host.xfer_byte({1'b0, a}, r);
		i_host.xfer_byte(8'h00, r);
		i_host.close_frame();
		chk(r, exp);
	endtask : rd_chk

	initial begin
		clk = 1'b0;
		rstn = 1'b0;
		ce = 1'b1;
		tx_active = 1'b0;
		pump_corr_auto = 5'h0B;
		vco_cal_code = 7'h2C;
		vco_cal_done = 1'b0;
		repeat (12) @(negedge clk);
		rstn = 1'b1;
		repeat (4) @(negedge clk);
		chk({4'h0, ook_th_len}, 8'h04);
		chk({6'h00, vco_cur_out}, 8'h03);
		rd_chk(OFS_DEMOD_TEST, 8'h00);
		rd_chk(OFS_PUMP_FORCE, 8'h00);
		rd_chk(OFS_PUMP_GAIN, 8'h8B);
		rd_chk(OFS_DIV_TRIM, 8'h00);
		rd_chk(OFS_VCO_TRIM, 8'h03);
		rd_chk(OFS_VCO_CAL, 8'h2C);
		for (int i = 0; i < 8; i++) begin
			wr(OFS_DEMOD_TEST, 8'h01 << i);
			chk(demod_ctrl, 8'h01 << i);
			chk({4'h0, ook_th_len}, (i == 3) ? 8'h08 : 8'h04);
			rd_chk(OFS_DEMOD_TEST, 8'h01 << i);
		end
		// burst write: the address advances to the next register after each data byte
		i_host.open_frame();
		i_host.xfer_byte({1'b1, OFS_DEMOD_TEST}, rx);
		i_host.xfer_byte(8'h00, rx);
		i_host.xfer_byte(8'h30, rx);
		i_host.close_frame();
		chk(demod_ctrl, 8'h00);
		chk(pump_force, 8'h30);
		wr(OFS_PUMP_FORCE, 8'hC7);
		chk(pump_force, 8'hC7);
		wr(OFS_PUMP_GAIN, 8'h75);
		chk({3'h0, pump_corr_out}, 8'h15);
		chk({6'h00, pump_gain}, 8'h01);
		rd_chk(OFS_PUMP_GAIN, 8'h75);
		pump_corr_auto = 5'h06;
		wr(OFS_PUMP_GAIN, 8'hDF);
		chk({3'h0, pump_corr_out}, 8'h06);
		rd_chk(OFS_PUMP_GAIN, 8'hC6);
		wr(OFS_DIV_TRIM, 8'h80);
		wr(OFS_VCO_TRIM, 8'hA9);
		chk(div_trim, 8'h80);
		chk({4'h0, vco_corr_out}, 8'h0A);
		chk({6'h00, vco_cur_out}, 8'h01);
		chk({7'h00, vco_corr_ov}, 8'h00);
		tx_active = 1'b1;
		repeat (3) @(negedge clk);
		chk({4'h0, vco_corr_out}, 8'h0F);
		chk({6'h00, vco_cur_out}, 8'h03);
		// with the clock enable low the outputs must stay put even as transmit ends
		ce = 1'b0;
		tx_active = 1'b0;
		repeat (3) @(negedge clk);
		chk({6'h00, vco_cur_out}, 8'h03);
		ce = 1'b1;
		repeat (3) @(negedge clk);
		chk({6'h00, vco_cur_out}, 8'h01);
		tx_active = 1'b1;
		wr(OFS_DIV_TRIM, 8'h00);
		wr(OFS_VCO_TRIM, 8'h69);
		chk({4'h0, vco_corr_out}, 8'h0A);
		chk({6'h00, vco_cur_out}, 8'h01);
		chk({7'h00, vco_corr_ov}, 8'h01);
		rd_chk(OFS_VCO_TRIM, 8'h69);
		wr(OFS_VCO_CAL, 8'hD5);
		chk({1'b0, vco_cal_out}, 8'h55);
		rd_chk(OFS_VCO_CAL, 8'h55);
		vco_cal_done = 1'b1;
		rd_chk(OFS_VCO_CAL, 8'hD5);
		wr(OFS_VCO_CAL, 8'h00);
		vco_cal_code = 7'h31;
		repeat (3) @(negedge clk);
		chk({1'b0, vco_cal_out}, 8'h31);
		rd_chk(OFS_VCO_CAL, 8'hB1);
		wr(7'h5C, 8'hFF);
		rd_chk(7'h5C, 8'h00);
		chk(demod_ctrl, 8'h00);
		conclude();
	end

	// about forty frames of some 220 clocks each; over four times that before giving up
	initial begin
		#200us;
		n_mismatch++;
		$display("watchdog expired at %0t", $time);
		conclude();
	end
endmodule : tb_radio_modem_synth_test_regs
